/* File: rtl/fault_pkg.sv */
// Constants shared by the fault supervisor and its helpers.
// Assumes a single 100 MHz clock domain; the long windows come from the
// timing capacitor ramp, not from clock counts.
// =====================================================================
// Fault supervisor package
// =====================================================================
package fault_pkg;
    // Clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // One fault window in ms, as built from the timing capacitor ramp
    localparam int WINDOW_MS = 128;
    // Default ramp cycles of the timing capacitor that make one window
    localparam int RAMP_CYCLES_PER_WINDOW = 1024;
    // Burst pattern period in windows
    localparam int BURST_PERIOD_WINDOWS = 8;
    // Windows with pulses inside one burst period
    localparam int BURST_ON_WINDOWS = 1;
    // Windows blanked inside one burst period
    localparam int BLANK_WINDOWS = BURST_PERIOD_WINDOWS - BURST_ON_WINDOWS;
    // Width of the blank window counter
    localparam int BLANK_CNT_W = 3;
    // Synchroniser depth is fixed at two flops
    localparam logic RESET_LOW = 1'b0;
    localparam logic RESET_HIGH = 1'b1;

    // Supervisor states, one-hot
    typedef enum logic [5:0] {
        ST_NORMAL = 6'h01,
        ST_FAULT_TIMING = 6'h02,
        ST_BLANK = 6'h04,
        ST_BURST_ON = 6'h08,
        ST_WAIT_UV = 6'h10,
        ST_OV_OFF = 6'h20
    } sup_state_e;
endpackage : fault_pkg

/* File: rtl/level_sync.sv */
// Two-flop synchroniser for one comparator level.
// Assumes the input is asynchronous to ref_clk; only the second flop
// is read outside.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Level synchroniser
// =====================================================================
module level_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg; // First stage, read only by the second

    // Two flops in series to settle metastability
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : level_sync
`default_nettype wire

/* File: rtl/ramp_divider.sv */
// Divider that turns timing capacitor ramp cycles into window pulses.
// Assumes ramp_pulse is a one-cycle pulse per completed up/down ramp.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Ramp cycle divider
// =====================================================================
module ramp_divider #(
    parameter int CYCLES = 1024
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic restart,
    input wire logic ramp_pulse,
    output logic window_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg; // Ramp cycles seen in this window

    // Count ramps; restart clears the count without a pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
            window_done <= 1'b0;
        end else if (restart) begin
            count_reg <= '0;
            window_done <= 1'b0;
        end else if (ramp_pulse) begin
            // Wrap at the end of the window and flag it
            if (count_reg == LAST) begin
                count_reg <= '0;
                window_done <= 1'b1;
            end else begin
                count_reg <= count_reg + CW'(1);
                window_done <= 1'b0;
            end
        end else begin
            window_done <= 1'b0;
        end
    end
endmodule : ramp_divider
`default_nettype wire

/* File: rtl/fault_timer_burst_supervisor.sv */
// Fault supervisor: error flag, fault window, hiccup burst and
// overvoltage shutdown for an offline flyback controller.
// Assumes comparator levels and the timing capacitor ramp comparator
// arrive asynchronously; all are synchronised here. Power-up drives resetn.
//
// What this block does
// - Sustained low virtual ground stops drive pulses
// - Burst: one window pulses, eight-window period
// - Loop restored while blanked: resume at upper crossing
// - Error flag high on either saturation direction
// - No error: capacitor on VCO, supervisor transparent
// - Error: capacitor to fault timer, VCO released
// - Fault timing counts ramp cycles through divider
// - Error clears early: abandon timing, back normal
// - Blanking keeps start-up source hiccuping
// - Overvoltage input shuts switching down at once
// - After overvoltage, restart at lower threshold if cleared
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Top module
// =====================================================================
module fault_timer_burst_supervisor
    import fault_pkg::*;
#(
    parameter int RAMP_CYCLES = RAMP_CYCLES_PER_WINDOW
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // Virtual ground saturated high (feedback lost upward)
    input wire logic vground_high_raw,
    // Virtual ground below its lower fault threshold
    input wire logic vground_low_raw,
    // Overvoltage shutdown input above its threshold
    input wire logic overvoltage_shutdown_input,
    // Supply above the upper undervoltage threshold
    input wire logic undervoltage_upper_threshold,
    // Supply below the lower undervoltage threshold
    input wire logic undervoltage_lower_threshold,
    // Timing capacitor ramp at its top turning point
    input wire logic timing_capacitor_peak,
    // Gate drive may issue pulses
    output logic drive_enable_reg,
    // Timing capacitor routed to the VCO (low: to the fault timer)
    output logic cap_to_vco_reg,
    // VCO steers frequency; low lets borderline_conduction_mode run free
    output logic vco_control_reg,
    // Internal error flag
    output logic error_flag_reg,
    // Confirmed fault, pulses being burst
    output logic fault_confirmed_reg,
    // Start-up current source enabled
    output logic startup_source_on_reg,
    // Overvoltage shutdown latched
    output logic overvoltage_latched_reg
);

    // =================================================================
    // Input synchronisers
    // =================================================================
    logic vg_high_s; // Synced high saturation
    logic vg_low_s; // Synced low fault level
    logic ov_s; // Synced overvoltage
    logic uv_upper_s; // Synced upper threshold level
    logic uv_lower_s; // Synced lower threshold level
    logic ramp_s; // Synced ramp peak level

    // Every comparator passes two flops first
    level_sync #(.RESET_VALUE(RESET_LOW)) u_sync_vgh (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(vground_high_raw),
        .sync_out(vg_high_s)
    );
    level_sync #(.RESET_VALUE(RESET_LOW)) u_sync_vgl (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(vground_low_raw),
        .sync_out(vg_low_s)
    );
    level_sync #(.RESET_VALUE(RESET_LOW)) u_sync_ov (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(overvoltage_shutdown_input),
        .sync_out(ov_s)
    );
    level_sync #(.RESET_VALUE(RESET_LOW)) u_sync_uvh (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(undervoltage_upper_threshold),
        .sync_out(uv_upper_s)
    );
    level_sync #(.RESET_VALUE(RESET_HIGH)) u_sync_uvl (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(undervoltage_lower_threshold),
        .sync_out(uv_lower_s)
    );
    level_sync #(.RESET_VALUE(RESET_LOW)) u_sync_ramp (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(timing_capacitor_peak),
        .sync_out(ramp_s)
    );

    // =================================================================
    // Edge detection on synced levels
    // =================================================================
    logic uv_upper_d_reg; // Previous upper level
    logic uv_lower_d_reg; // Previous lower level
    logic ramp_d_reg; // Previous ramp level
    logic uv_upper_rise; // Supply crossed above upper threshold
    logic uv_lower_fall; // Supply fell through lower threshold
    logic ramp_pulse; // One completed ramp cycle

    // Delay the synced levels one cycle for edge finding
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            uv_upper_d_reg <= 1'b0;
            uv_lower_d_reg <= 1'b1;
            ramp_d_reg <= 1'b0;
        end else begin
            uv_upper_d_reg <= uv_upper_s;
            uv_lower_d_reg <= uv_lower_s;
            ramp_d_reg <= ramp_s;
        end
    end

    assign uv_upper_rise = uv_upper_s & ~uv_upper_d_reg;
    assign uv_lower_fall = uv_lower_s & ~uv_lower_d_reg;
    assign ramp_pulse = ramp_s & ~ramp_d_reg;

    // =================================================================
    // Error flag
    // =================================================================
    logic error_now; // Loop cannot hold the virtual ground

    // Either saturation direction counts as an error
    assign error_now = vg_high_s | vg_low_s;

    // Registered copy for the outside
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            error_flag_reg <= 1'b0;
        end else begin
            error_flag_reg <= error_now;
        end
    end

    // =================================================================
    // Window divider on the timing capacitor
    // =================================================================
    sup_state_e state_reg; // Current supervisor state
    sup_state_e state_next; // Next supervisor state
    logic div_restart; // Start a fresh window
    logic window_done; // One window has elapsed

    // Restart on every state change and whenever the VCO owns the cap
    assign div_restart = (state_next != state_reg) | (state_reg == ST_NORMAL)
        | (state_reg == ST_WAIT_UV) | (state_reg == ST_OV_OFF);

    // Ramp cycles divided down to the long window
    ramp_divider #(.CYCLES(RAMP_CYCLES)) u_divider (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .restart(div_restart),
        .ramp_pulse(ramp_pulse),
        .window_done(window_done)
    );

    // =================================================================
    // Blank window counter
    // =================================================================
    logic [BLANK_CNT_W-1:0] blank_cnt_reg; // Blanked windows so far
    localparam logic [BLANK_CNT_W-1:0] BLANK_LAST = BLANK_CNT_W'(BLANK_WINDOWS - 1);

    // Count windows spent blanked; cleared outside blanking
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            blank_cnt_reg <= '0;
        end else if (state_reg != ST_BLANK) begin
            blank_cnt_reg <= '0;
        end else if (window_done) begin
            blank_cnt_reg <= blank_cnt_reg + BLANK_CNT_W'(1);
        end
    end

    // =================================================================
    // Supervisor state machine
    // =================================================================
    // Next-state choice; overvoltage outranks every fault path
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                if (ov_s) begin
                    state_next = ST_OV_OFF;
                end else if (error_now) begin
                    state_next = ST_FAULT_TIMING;
                end
            end
            ST_FAULT_TIMING: begin
                if (ov_s) begin
                    state_next = ST_OV_OFF;
                end else if (!error_now) begin
                    state_next = ST_NORMAL;
                end else if (window_done) begin
                    state_next = ST_BLANK;
                end
            end
            ST_BLANK: begin
                if (ov_s) begin
                    state_next = ST_OV_OFF;
                end else if (!error_now) begin
                    state_next = ST_WAIT_UV;
                end else if (window_done && blank_cnt_reg == BLANK_LAST) begin
                    state_next = ST_BURST_ON;
                end
            end
            ST_BURST_ON: begin
                if (ov_s) begin
                    state_next = ST_OV_OFF;
                end else if (!error_now) begin
                    state_next = ST_NORMAL;
                end else if (window_done) begin
                    state_next = ST_BLANK;
                end
            end
            ST_WAIT_UV: begin
                if (ov_s) begin
                    state_next = ST_OV_OFF;
                end else if (uv_upper_rise) begin
                    state_next = ST_NORMAL;
                end
            end
            ST_OV_OFF: begin
                // New start-up at the lower crossing, only once cleared
                if (uv_lower_fall && !ov_s) begin
                    state_next = ST_WAIT_UV;
                end
            end
            default: begin
                state_next = ST_NORMAL;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // =================================================================
    // Drive and capacitor routing outputs
    // =================================================================
    // Pulses allowed in normal, fault timing and the burst-on window
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_enable_reg <= 1'b0;
        end else begin
            drive_enable_reg <= (state_next == ST_NORMAL)
                | (state_next == ST_FAULT_TIMING)
                | (state_next == ST_BURST_ON);
        end
    end

    // Capacitor and VCO follow the error path
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cap_to_vco_reg <= 1'b1;
            vco_control_reg <= 1'b1;
        end else begin
            cap_to_vco_reg <= (state_next == ST_NORMAL) | (state_next == ST_WAIT_UV)
                | (state_next == ST_OV_OFF);
            vco_control_reg <= (state_next == ST_NORMAL);
        end
    end

    // Confirmed fault spans blanking and burst windows
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fault_confirmed_reg <= 1'b0;
        end else begin
            fault_confirmed_reg <= (state_next == ST_BLANK) | (state_next == ST_BURST_ON);
        end
    end

    // Overvoltage shutdown held until the restart condition
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overvoltage_latched_reg <= 1'b0;
        end else begin
            overvoltage_latched_reg <= (state_next == ST_OV_OFF);
        end
    end

    // =================================================================
    // Start-up source hysteresis
    // =================================================================
    // On at the lower crossing, off at the upper, in every state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            startup_source_on_reg <= 1'b1;
        end else if (uv_lower_fall) begin
            startup_source_on_reg <= 1'b1;
        end else if (uv_upper_rise) begin
            startup_source_on_reg <= 1'b0;
        end
    end

endmodule : fault_timer_burst_supervisor
`default_nettype wire

/* File: verif/fault_timer_burst_supervisor_props.sv */
// Checker for the fault supervisor, bound to its top module ports.
// Assumes one clock domain and comparator inputs held low during reset.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Supervisor properties
// =====================================================================
module fault_props (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic vground_high_raw,
    input wire logic vground_low_raw,
    input wire logic overvoltage_shutdown_input,
    input wire logic undervoltage_upper_threshold,
    input wire logic undervoltage_lower_threshold,
    input wire logic timing_capacitor_peak,
    input wire logic drive_enable_reg,
    input wire logic cap_to_vco_reg,
    input wire logic vco_control_reg,
    input wire logic error_flag_reg,
    input wire logic fault_confirmed_reg,
    input wire logic startup_source_on_reg,
    input wire logic overvoltage_latched_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Error flag follows either saturation three edges late
    property p_err; error_flag_reg == $past(vground_low_raw || vground_high_raw, 3); endproperty
    a_err: assert property (p_err) else $error("error flag latency wrong");
    // VCO steering only with capacitor on VCO and no fault
    property p_vco; vco_control_reg |-> cap_to_vco_reg && !fault_confirmed_reg && !overvoltage_latched_reg; endproperty
    a_vco: assert property (p_vco) else $error("vco steering outside normal");
    // Error from normal takes capacitor and frequency control away
    property p_take; $rose(error_flag_reg) && $past(vco_control_reg) |-> !cap_to_vco_reg && !vco_control_reg;
    endproperty
    a_take: assert property (p_take) else $error("capacitor not handed to timer");
    // Confirmed fault stops pulses
    property p_conf; $rose(fault_confirmed_reg) |-> !drive_enable_reg && !cap_to_vco_reg; endproperty
    a_conf: assert property (p_conf) else $error("pulses run at fault");
    // Early clear from timing or burst-on returns to normal at once
    property p_abort; $fell(error_flag_reg) && $past(drive_enable_reg && !cap_to_vco_reg)
        |-> vco_control_reg && cap_to_vco_reg && drive_enable_reg; endproperty
    a_abort: assert property (p_abort) else $error("early clear not normal");
    // Resume from waiting only on upper threshold
    property p_resume; $rose(drive_enable_reg) && !$past(vco_control_reg) && !fault_confirmed_reg
        |-> vco_control_reg && cap_to_vco_reg && $past(undervoltage_upper_threshold, 3); endproperty
    a_resume: assert property (p_resume) else $error("resume not on upper threshold");
    // Overvoltage latches three edges after the input
    property p_ovlatch; overvoltage_shutdown_input |-> ##3 overvoltage_latched_reg; endproperty
    a_ovlatch: assert property (p_ovlatch) else $error("overvoltage not latched");
    property p_ovoff; overvoltage_latched_reg |-> !drive_enable_reg; endproperty
    a_ovoff: assert property (p_ovoff) else $error("pulses in overvoltage");
    // Overvoltage ends only on lower threshold with input clear
    property p_ovend; $fell(overvoltage_latched_reg) |-> !drive_enable_reg
        && $past(undervoltage_lower_threshold, 3) && !$past(overvoltage_shutdown_input, 3); endproperty
    a_ovend: assert property (p_ovend) else $error("overvoltage left wrongly");
    // Start-up source follows the two thresholds
    property p_suon; $rose(undervoltage_lower_threshold) |-> ##3 startup_source_on_reg; endproperty
    a_suon: assert property (p_suon) else $error("start-up source not on");
    property p_suoff; $rose(undervoltage_upper_threshold) |-> ##3 !startup_source_on_reg; endproperty
    a_suoff: assert property (p_suoff) else $error("start-up source not off");
endmodule : fault_props
bind fault_timer_burst_supervisor fault_props fp_u (.ref_clk(ref_clk), .resetn(resetn),
    .vground_high_raw(vground_high_raw), .vground_low_raw(vground_low_raw),
    .overvoltage_shutdown_input(overvoltage_shutdown_input),
    .undervoltage_upper_threshold(undervoltage_upper_threshold),
    .undervoltage_lower_threshold(undervoltage_lower_threshold),
    .timing_capacitor_peak(timing_capacitor_peak), .drive_enable_reg(drive_enable_reg),
    .cap_to_vco_reg(cap_to_vco_reg), .vco_control_reg(vco_control_reg), .error_flag_reg(error_flag_reg),
    .fault_confirmed_reg(fault_confirmed_reg), .startup_source_on_reg(startup_source_on_reg),
    .overvoltage_latched_reg(overvoltage_latched_reg));
`default_nettype wire

/* File: verif/cap_ramp_model.sv */
// Timing capacitor ramp model: a top pulse per up/down ramp.
// Assumes ref_clk as time base; slow stretches the ramp period.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Ramp model
// =====================================================================
module cap_ramp_model #(
    parameter int FAST = 10,
    parameter int SLOW = 24
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic slow,
    output logic timing_capacitor_peak
);
    int cnt; // Position inside one ramp
    // Ramp keeps running; peak held three clocks so no edge merges
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            timing_capacitor_peak <= 1'b0;
        end else begin
            cnt <= (cnt >= (slow ? SLOW : FAST) - 1) ? 0 : cnt + 1;
            timing_capacitor_peak <= (cnt < 3);
        end
    end
endmodule : cap_ramp_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the fault supervisor.
// Assumes the ramp model as capacitor and a shortened window.
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Testbench
// =====================================================================
module tb;
    localparam int RC = 4; // Ramp cycles per window
    logic ref_clk = 1'b0, resetn = 1'b0, slow = 1'b0;
    logic vground_high_raw = 1'b0, vground_low_raw = 1'b0, overvoltage_shutdown_input = 1'b0;
    logic undervoltage_upper_threshold = 1'b0, undervoltage_lower_threshold = 1'b0;
    logic timing_capacitor_peak, drive_enable_reg, cap_to_vco_reg, vco_control_reg;
    logic error_flag_reg, fault_confirmed_reg, startup_source_on_reg, overvoltage_latched_reg;
    logic peak_q = 1'b0; // Ramp top seen last clock
    int rises = 0, err_total = 0, compares = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    cap_ramp_model ramp_u (.ref_clk(ref_clk), .resetn(resetn), .slow(slow),
        .timing_capacitor_peak(timing_capacitor_peak));
    fault_timer_burst_supervisor #(.RAMP_CYCLES(RC)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .vground_high_raw(vground_high_raw), .vground_low_raw(vground_low_raw),
        .overvoltage_shutdown_input(overvoltage_shutdown_input),
        .undervoltage_upper_threshold(undervoltage_upper_threshold),
        .undervoltage_lower_threshold(undervoltage_lower_threshold),
        .timing_capacitor_peak(timing_capacitor_peak), .drive_enable_reg(drive_enable_reg),
        .cap_to_vco_reg(cap_to_vco_reg), .vco_control_reg(vco_control_reg), .error_flag_reg(error_flag_reg),
        .fault_confirmed_reg(fault_confirmed_reg), .startup_source_on_reg(startup_source_on_reg),
        .overvoltage_latched_reg(overvoltage_latched_reg));
    // Ramp rise counter and hang guard
    always @(posedge ref_clk) begin
        peak_q <= timing_capacitor_peak;
        if (timing_capacitor_peak && !peak_q) rises++;
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // Closing report
    task give_verdict();
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // Wait n clocks, land just after the edge
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Ramp counts may differ by one through sync alignment
    task chk_cnt(input int got, input int exp);
        compares++;
        if (got < exp - 1 || got > exp + 1) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt
    // Wait for drive level, return ramp rises seen meanwhile
    task meas(input logic val, output int r);
        int n;
        int r0;
        r0 = rises;
        n = 0;
        while (drive_enable_reg !== val && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, drive_enable_reg, val);
        end
        r = rises - r0;
    endtask : meas
    // Reset values, then normal operation
    task t_reset();
        cyc(12);
        chk(drive_enable_reg, 1'b0);
        chk(cap_to_vco_reg, 1'b1);
        chk(startup_source_on_reg, 1'b1);
        resetn = 1'b1;
        cyc(4);
        chk(drive_enable_reg, 1'b1);
        chk(vco_control_reg, 1'b1);
        undervoltage_upper_threshold = 1'b1;
        cyc(4);
        chk(startup_source_on_reg, 1'b0);
    endtask : t_reset
    // Short low-side fault is abandoned before the window ends
    task t_transient();
        vground_low_raw = 1'b1;
        cyc(3);
        chk(error_flag_reg, 1'b1);
        chk(cap_to_vco_reg, 1'b0);
        chk(vco_control_reg, 1'b0);
        chk(drive_enable_reg, 1'b1);
        cyc(15);
        vground_low_raw = 1'b0;
        cyc(3);
        chk(vco_control_reg, 1'b1);
        chk(cap_to_vco_reg, 1'b1);
        cyc(60);
        chk(drive_enable_reg, 1'b1);
        chk(fault_confirmed_reg, 1'b0);
    endtask : t_transient
    // High-side fault on a slow ramp: window and burst pattern
    task t_burst();
        int r;
        slow = 1'b1;
        vground_high_raw = 1'b1;
        meas(1'b0, r);
        chk_cnt(r, RC);
        chk(fault_confirmed_reg, 1'b1);
        meas(1'b1, r);
        chk_cnt(r, 7 * RC);
        meas(1'b0, r);
        chk_cnt(r, RC);
    endtask : t_burst
    // Hiccup while blanked, then recovery on upper threshold
    task t_recover();
        undervoltage_upper_threshold = 1'b0;
        undervoltage_lower_threshold = 1'b1;
        cyc(4);
        chk(startup_source_on_reg, 1'b1);
        undervoltage_lower_threshold = 1'b0;
        cyc(1);
        undervoltage_upper_threshold = 1'b1;
        cyc(4);
        chk(startup_source_on_reg, 1'b0);
        vground_high_raw = 1'b0;
        cyc(6);
        chk(error_flag_reg, 1'b0);
        chk(drive_enable_reg, 1'b0);
        undervoltage_upper_threshold = 1'b0;
        cyc(2);
        undervoltage_upper_threshold = 1'b1;
        cyc(3);
        chk(drive_enable_reg, 1'b1);
        chk(vco_control_reg, 1'b1);
        slow = 1'b0;
    endtask : t_recover
    // Overvoltage shutdown, refused and accepted restarts
    task t_overvolt();
        overvoltage_shutdown_input = 1'b1;
        cyc(3);
        chk(overvoltage_latched_reg, 1'b1);
        chk(drive_enable_reg, 1'b0);
        chk(cap_to_vco_reg, 1'b1);
        undervoltage_lower_threshold = 1'b1;
        cyc(4);
        chk(overvoltage_latched_reg, 1'b1);
        chk(startup_source_on_reg, 1'b1);
        undervoltage_lower_threshold = 1'b0;
        overvoltage_shutdown_input = 1'b0;
        cyc(4);
        chk(overvoltage_latched_reg, 1'b1);
        undervoltage_lower_threshold = 1'b1;
        cyc(3);
        chk(overvoltage_latched_reg, 1'b0);
        chk(drive_enable_reg, 1'b0);
        undervoltage_lower_threshold = 1'b0;
        undervoltage_upper_threshold = 1'b0;
        cyc(2);
        undervoltage_upper_threshold = 1'b1;
        cyc(3);
        chk(drive_enable_reg, 1'b1);
    endtask : t_overvolt
    // Main sequence
    initial begin
        t_reset();
        t_transient();
        t_burst();
        t_recover();
        t_overvolt();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
